// *** hdl/cdb_params.svh ***
`ifndef CDB_PARAMS_SVH
`define CDB_PARAMS_SVH

// Address and data widths of the register port
`define CDB_ADDR_W 24
`define CDB_DATA_W 32

// Register byte addresses
`define CDB_OFF_PROC_ID 24'hff_ff84
`define CDB_OFF_RAM_BASE 24'hff_ff90
`define CDB_OFF_CTL 24'hff_ffa0
`define CDB_OFF_BAR1 24'hff_ffb4
`define CDB_OFF_BAR2 24'hff_ffb8
`define CDB_OFF_BAR3 24'hff_ffbc
`define CDB_OFF_BAR4 24'hff_ffd0
`define CDB_OFF_STATUS 24'hff_ffe0
`define CDB_OFF_MASK 24'hff_ffe4

// Field positions in the debug control byte
`define CDB_BIT_MODE 0
`define CDB_BIT_STEP 1
`define CDB_BIT_BE0 2
`define CDB_BIT_BE1 3
`define CDB_BIT_REQ 4
`define CDB_BIT_BE2 5
`define CDB_BIT_BE3 6
`define CDB_BIT_BE4 7

// Fixed and reset values
`define CDB_RAM_BASE 24'h00_07c0
`define CDB_BAR_RST 24'h00_0000
`define CDB_BAR_N 4

// Event bits in the interrupt status and mask registers
`define CDB_EV_BREAK 0
`define CDB_EV_STEP 1
`define CDB_EV_REQ 2
`define CDB_EV_N 3

`endif

// *** hdl/cdb_pkg.sv ***
package cdb_pkg;

   // Register selected by the current bus address
   typedef enum logic [3:0] {
      CDB_SEL_NONE,
      CDB_SEL_ID,
      CDB_SEL_RAM,
      CDB_SEL_CTL,
      CDB_SEL_BAR1,
      CDB_SEL_BAR2,
      CDB_SEL_BAR3,
      CDB_SEL_BAR4,
      CDB_SEL_STAT,
      CDB_SEL_MASK
   } cdb_sel_t;

endpackage : cdb_pkg

// *** hdl/cdb_break_unit.sv ***
`timescale 1ns/1ns
`default_nettype none
`include "cdb_params.svh"

module cdb_break_unit #(
   parameter int AW = 24
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wr_i,
   input wire logic [AW-1:0] wdata_i,
   input wire logic enable_i,
   input wire logic fetch_valid_i,
   input wire logic [AW-1:0] fetch_addr_i,
   output logic [AW-1:0] addr_o,
   output logic hit_o
);

   logic [AW-1:0] addr_q;

   // Break address storage, full range writable
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         addr_q <= AW'(`CDB_BAR_RST);
      end else if (wr_i) begin
         addr_q <= wdata_i;
      end
   end

   // Match of an enabled break against the fetch address
   assign addr_o = addr_q;
   assign hit_o = enable_i & fetch_valid_i & (fetch_addr_i == addr_q);

endmodule : cdb_break_unit
`default_nettype wire

// *** hdl/cdb_irq.sv ***
`timescale 1ns/1ns
`default_nettype none

module cdb_irq #(
   parameter int N = 3
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [N-1:0] set_i,
   input wire logic wr_clr_i,
   input wire logic wr_mask_i,
   input wire logic [N-1:0] wdata_i,
   output logic [N-1:0] status_o,
   output logic [N-1:0] mask_o,
   output logic irq_o
);

   logic [N-1:0] status_q;
   logic [N-1:0] mask_q;
   logic [N-1:0] clr;

   // Write one to clear; a new event in the same cycle wins
   assign clr = wr_clr_i ? wdata_i : '0;

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         status_q <= '0;
      end else begin
         status_q <= (status_q & ~clr) | set_i;
      end
   end

   // Mask register, one enables the event onto the line
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         mask_q <= '0;
      end else if (wr_mask_i) begin
         mask_q <= wdata_i;
      end
   end

   assign status_o = status_q;
   assign mask_o = mask_q;
   assign irq_o = |(status_q & mask_q);

endmodule : cdb_irq
`default_nettype wire

// *** hdl/cdb_top.sv ***
`timescale 1ns/1ns
`default_nettype none
`include "cdb_params.svh"

module cdb_top
   import cdb_pkg::*;
#(
   parameter logic [7:0] PROC_ID = 8'h5a // Arbitrary value
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [23:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   output logic [31:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   input wire logic fetch_valid_i,
   input wire logic [23:0] fetch_addr_i,
   input wire logic [23:0] break_zero_addr_i,
   input wire logic step_done_i,
   input wire logic debug_req_i,
   input wire logic debug_exit_i,
   output logic debug_mode_o,
   output logic debug_entry_o,
   output logic single_step_enable_o,
   output logic [4:0] break_enable_o,
   output logic irq_o
);

   localparam int EVN = `CDB_EV_N;
   localparam int BN = `CDB_BAR_N;

   cdb_sel_t sel;
   logic setup;
   logic wr_en;
   logic ctl_wr;
   logic [BN-1:0] bar_wr;
   logic [BN-1:0] bar_hit;
   logic [23:0] bar_addr [BN];
   logic zero_hit;
   logic hit_any;
   logic step_ev;
   logic entry;
   logic [4:0] break_en_q;
   logic step_en_q;
   logic req_flag_q;
   logic dmode_q;
   logic entry_q;
   logic [7:0] ctl_byte;
   logic [EVN-1:0] ev_set;
   logic [EVN-1:0] status;
   logic [EVN-1:0] mask;
   logic [31:0] rdata_d;
   logic [31:0] rdata_q;
   logic err_d;
   logic err_q;

   // Address decode of the bus request
   always_comb begin
      case (paddr_i)
         `CDB_OFF_PROC_ID: sel = CDB_SEL_ID;
         `CDB_OFF_RAM_BASE: sel = CDB_SEL_RAM;
         `CDB_OFF_CTL: sel = CDB_SEL_CTL;
         `CDB_OFF_BAR1: sel = CDB_SEL_BAR1;
         `CDB_OFF_BAR2: sel = CDB_SEL_BAR2;
         `CDB_OFF_BAR3: sel = CDB_SEL_BAR3;
         `CDB_OFF_BAR4: sel = CDB_SEL_BAR4;
         `CDB_OFF_STATUS: sel = CDB_SEL_STAT;
         `CDB_OFF_MASK: sel = CDB_SEL_MASK;
         default: sel = CDB_SEL_NONE;
      endcase
   end

   // Bus phases; writes land at the end of the access phase
   assign setup = psel_i & ~penable_i;
   assign wr_en = psel_i & penable_i & pwrite_i;
   assign ctl_wr = wr_en & (sel == CDB_SEL_CTL);
   assign bar_wr[0] = wr_en & (sel == CDB_SEL_BAR1);
   assign bar_wr[1] = wr_en & (sel == CDB_SEL_BAR2);
   assign bar_wr[2] = wr_en & (sel == CDB_SEL_BAR3);
   assign bar_wr[3] = wr_en & (sel == CDB_SEL_BAR4);

   // Break enables, one per break, cleared at reset
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         break_en_q <= 5'h00;
      end else if (ctl_wr) begin
         break_en_q[0] <= pwdata_i[`CDB_BIT_BE0];
         break_en_q[1] <= pwdata_i[`CDB_BIT_BE1];
         break_en_q[2] <= pwdata_i[`CDB_BIT_BE2];
         break_en_q[3] <= pwdata_i[`CDB_BIT_BE3];
         break_en_q[4] <= pwdata_i[`CDB_BIT_BE4];
      end
   end

   // Single step enable
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         step_en_q <= 1'b0;
      end else if (ctl_wr) begin
         step_en_q <= pwdata_i[`CDB_BIT_STEP];
      end
   end

   // Debug request flag; a request in the clearing cycle wins
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         req_flag_q <= 1'b0;
      end else if (debug_req_i) begin
         req_flag_q <= 1'b1;
      end else if (ctl_wr && pwdata_i[`CDB_BIT_REQ]) begin
         req_flag_q <= 1'b0;
      end
   end

   // Break address registers with their comparators
   genvar g;
   generate
      for (g = 0; g < BN; g++) begin : g_bar
         cdb_break_unit #(
            .AW(24)
         ) u_bar (
            .clk_i(clk_i),
            .rst_i(rst_i),
            .wr_i(bar_wr[g]),
            .wdata_i(pwdata_i[23:0]),
            .enable_i(break_en_q[g+1]),
            .fetch_valid_i(fetch_valid_i),
            .fetch_addr_i(fetch_addr_i),
            .addr_o(bar_addr[g]),
            .hit_o(bar_hit[g])
         );
      end
   endgenerate

   // Break zero compares against an address held outside this block
   assign zero_hit = break_en_q[0] & fetch_valid_i & (fetch_addr_i == break_zero_addr_i);
   assign hit_any = ~dmode_q & (zero_hit | (|bar_hit));
   assign step_ev = ~dmode_q & step_en_q & step_done_i;
   assign entry = hit_any | step_ev | (~dmode_q & debug_req_i);

   // Debug mode indicator; software cannot write it, entry beats exit
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         dmode_q <= 1'b0;
      end else if (entry) begin
         dmode_q <= 1'b1;
      end else if (debug_exit_i) begin
         dmode_q <= 1'b0;
      end
   end

   // One-cycle pulse to the core on each entry
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         entry_q <= 1'b0;
      end else begin
         entry_q <= entry;
      end
   end

   // Events raise sticky interrupt status
   assign ev_set[`CDB_EV_BREAK] = hit_any;
   assign ev_set[`CDB_EV_STEP] = step_ev;
   assign ev_set[`CDB_EV_REQ] = debug_req_i;

   cdb_irq #(
      .N(EVN)
   ) u_irq (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .set_i(ev_set),
      .wr_clr_i(wr_en & (sel == CDB_SEL_STAT)),
      .wr_mask_i(wr_en & (sel == CDB_SEL_MASK)),
      .wdata_i(pwdata_i[EVN-1:0]),
      .status_o(status),
      .mask_o(mask),
      .irq_o(irq_o)
   );

   // Debug control byte as software reads it
   always_comb begin
      ctl_byte = 8'h00;
      ctl_byte[`CDB_BIT_BE4] = break_en_q[4];
      ctl_byte[`CDB_BIT_BE3] = break_en_q[3];
      ctl_byte[`CDB_BIT_BE2] = break_en_q[2];
      ctl_byte[`CDB_BIT_REQ] = req_flag_q;
      ctl_byte[`CDB_BIT_BE1] = break_en_q[1];
      ctl_byte[`CDB_BIT_BE0] = break_en_q[0];
      ctl_byte[`CDB_BIT_STEP] = step_en_q;
      ctl_byte[`CDB_BIT_MODE] = dmode_q;
   end

   // Read data mux; unmapped addresses answer with an error
   always_comb begin
      rdata_d = 32'h0000_0000;
      err_d = 1'b0;
      case (sel)
         CDB_SEL_ID: rdata_d = {24'h00_0000, PROC_ID};
         CDB_SEL_RAM: rdata_d = {8'h00, `CDB_RAM_BASE};
         CDB_SEL_CTL: rdata_d = {24'h00_0000, ctl_byte};
         CDB_SEL_BAR1: rdata_d = {8'h00, bar_addr[0]};
         CDB_SEL_BAR2: rdata_d = {8'h00, bar_addr[1]};
         CDB_SEL_BAR3: rdata_d = {8'h00, bar_addr[2]};
         CDB_SEL_BAR4: rdata_d = {8'h00, bar_addr[3]};
         CDB_SEL_STAT: rdata_d = {{(32-EVN){1'b0}}, status};
         CDB_SEL_MASK: rdata_d = {{(32-EVN){1'b0}}, mask};
         default: err_d = 1'b1;
      endcase
   end

   // Answer captured in the setup cycle, shown in the access phase
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         rdata_q <= 32'h0000_0000;
         err_q <= 1'b0;
      end else if (setup) begin
         rdata_q <= pwrite_i ? 32'h0000_0000 : rdata_d;
         err_q <= err_d;
      end
   end

   assign prdata_o = rdata_q;
   assign pslverr_o = err_q & psel_i & penable_i;
   assign pready_o = 1'b1;
   assign debug_mode_o = dmode_q;
   assign debug_entry_o = entry_q;
   assign single_step_enable_o = step_en_q;
   assign break_enable_o = break_en_q;

   // Checks kept beside the logic
   a_break_en_write: assert property (@(posedge clk_i) disable iff (rst_i)
      ctl_wr |=> (ctl_byte[7:5] == $past(pwdata_i[7:5])) && (ctl_byte[3:2] == $past(pwdata_i[3:2])))
      else $error("break enables not taken from the write");

   a_req_flag_set: assert property (@(posedge clk_i) disable iff (rst_i)
      debug_req_i |=> req_flag_q)
      else $error("request flag not set by a request");

   a_req_flag_hold: assert property (@(posedge clk_i) disable iff (rst_i)
      (req_flag_q && !(ctl_wr && pwdata_i[`CDB_BIT_REQ])) |=> req_flag_q)
      else $error("request flag dropped without a clearing write");

   a_req_flag_clr: assert property (@(posedge clk_i) disable iff (rst_i)
      (ctl_wr && pwdata_i[`CDB_BIT_REQ] && !debug_req_i) |=> !req_flag_q)
      else $error("request flag not cleared by writing one");

   a_step_en_write: assert property (@(posedge clk_i) disable iff (rst_i)
      ctl_wr |=> single_step_enable_o == $past(pwdata_i[`CDB_BIT_STEP]))
      else $error("step enable does not follow the write");

   a_mode_read_only: assert property (@(posedge clk_i) disable iff (rst_i)
      (ctl_wr && !entry && !debug_exit_i) |=> $stable(debug_mode_o))
      else $error("debug mode changed by a register write");

   a_ram_base_read: assert property (@(posedge clk_i) disable iff (rst_i)
      (setup && !pwrite_i && sel == CDB_SEL_RAM) |=> prdata_o == 32'h0000_07c0)
      else $error("debug RAM base reads wrong");

   a_bar_roundtrip: assert property (@(posedge clk_i) disable iff (rst_i)
      bar_wr[0] |=> bar_addr[0] == $past(pwdata_i[23:0]))
      else $error("break address not stored");

   a_bar_top_zero: assert property (@(posedge clk_i) disable iff (rst_i)
      (setup && !pwrite_i && sel == CDB_SEL_BAR4) |=> prdata_o[31:24] == 8'h00)
      else $error("reserved break address byte not zero");

   a_id_read: assert property (@(posedge clk_i) disable iff (rst_i)
      (setup && !pwrite_i && sel == CDB_SEL_ID) |=> prdata_o == {24'h00_0000, PROC_ID})
      else $error("identity byte reads wrong");

   a_break_entry: assert property (@(posedge clk_i) disable iff (rst_i)
      (!debug_mode_o && fetch_valid_i && break_en_q[1] && fetch_addr_i == bar_addr[0])
      |=> debug_mode_o && debug_entry_o)
      else $error("break match did not enter debug mode");

   a_step_entry: assert property (@(posedge clk_i) disable iff (rst_i)
      (!debug_mode_o && step_en_q && step_done_i) |=> debug_mode_o ##1 !debug_entry_o)
      else $error("completed step did not enter debug mode once");

   a_irq_level: assert property (@(posedge clk_i) disable iff (rst_i)
      (!debug_mode_o && debug_req_i && mask[`CDB_EV_REQ]) |=> irq_o)
      else $error("unmasked request did not raise the interrupt");

   // Entry is a single-cycle pulse and unmapped accesses flag an error
   a_entry_one_cycle: assert property (@(posedge clk_i) disable iff (rst_i)
      debug_entry_o |=> !debug_entry_o)
      else $error("entry pulse lasted more than one cycle");

   a_err_unmapped: assert property (@(posedge clk_i) disable iff (rst_i)
      (setup && sel == CDB_SEL_NONE) ##1 (psel_i && penable_i) |-> pslverr_o)
      else $error("unmapped access gave no error");

endmodule : cdb_top
`default_nettype wire

// *** test/cdb_core_model.sv ***
`timescale 1ns/1ns
`default_nettype none

// Behavioural core: fetches, completes steps, requests and leaves debug mode
module cdb_core_model (
   input wire logic clk_i,
   output logic fetch_valid_o,
   output logic [23:0] fetch_addr_o,
   output logic step_done_o,
   output logic debug_req_o,
   output logic debug_exit_o
);
   // Quiet link at time zero
   initial begin
      fetch_valid_o = 1'b0;
      fetch_addr_o = 24'h00_0000;
      step_done_o = 1'b0;
      debug_req_o = 1'b0;
      debug_exit_o = 1'b0;
   end

   // One-cycle event after gap idle cycles; kind 0 fetch, 1 step, 2 request, 3 exit
   task automatic pulse(input int kind, input logic [23:0] a, input int gap);
      repeat (gap) @(posedge clk_i);
      fetch_valid_o <= (kind == 0);
      fetch_addr_o <= a;
      step_done_o <= (kind == 1);
      debug_req_o <= (kind == 2);
      debug_exit_o <= (kind == 3);
      @(posedge clk_i);
      fetch_valid_o <= 1'b0;
      fetch_addr_o <= ~a; // Stale address never matches by luck
      step_done_o <= 1'b0;
      debug_req_o <= 1'b0;
      debug_exit_o <= 1'b0;
   endtask : pulse
endmodule : cdb_core_model
`default_nettype wire

// *** test/tb_core_debug_break_registers.sv ***
`timescale 1ns/1ns
`default_nettype none
`include "cdb_params.svh"

module tb_core_debug_break_registers
   import cdb_pkg::*;
;
   localparam logic [7:0] ID = 8'h3c; // Arbitrary value
   typedef struct packed {logic rd; logic err; logic [31:0] d;} cdb_note_t;
   logic clk_i, rst_i, psel_i, penable_i, pwrite_i, pready_o, pslverr_o, irq_o;
   logic fetch_valid_i, step_done_i, debug_req_i, debug_exit_i;
   logic debug_mode_o, debug_entry_o, single_step_enable_o;
   logic [23:0] paddr_i, fetch_addr_i, break_zero_addr_i;
   logic [31:0] pwdata_i, prdata_o, v [4];
   logic [4:0] break_enable_o;
   logic [23:0] bar_a [4] = '{`CDB_OFF_BAR1, `CDB_OFF_BAR2, `CDB_OFF_BAR3, `CDB_OFF_BAR4};
   int bp [5] = '{`CDB_BIT_BE0, `CDB_BIT_BE1, `CDB_BIT_BE2, `CDB_BIT_BE3, `CDB_BIT_BE4};
   int fail_count, check_count;
   cdb_note_t note_q[$];

   // 125 MHz clock
   initial begin
      clk_i = 1'b0;
      forever #4 clk_i = ~clk_i;
   end

   cdb_top #(.PROC_ID(ID)) dut_u (.clk_i, .rst_i, .psel_i, .penable_i, .pwrite_i, .paddr_i,
      .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .fetch_valid_i, .fetch_addr_i,
      .break_zero_addr_i, .step_done_i, .debug_req_i, .debug_exit_i, .debug_mode_o,
      .debug_entry_o, .single_step_enable_o, .break_enable_o, .irq_o);

   cdb_core_model core_u (.clk_i, .fetch_valid_o(fetch_valid_i), .fetch_addr_o(fetch_addr_i),
      .step_done_o(step_done_i), .debug_req_o(debug_req_i), .debug_exit_o(debug_exit_i));

   // Verdict and end of run
   task results;
      $display("checks %0d mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : results

   // Compare bus read data
   task chk_data(input logic [31:0] g, input logic [31:0] e);
      check_count++;
      if (g !== e) begin
         fail_count++;
         $display("unexpected at %0t: read %h want %h", $time, g, e);
      end
   endtask : chk_data

   // Compare core-side and status pins
   task chk_pin(input logic [7:0] g, input logic [7:0] e);
      check_count++;
      if (g !== e) begin
         fail_count++;
         $display("unexpected at %0t: pins %h want %h", $time, g, e);
      end
   endtask : chk_pin

   // One APB transfer; psel stays up so another setup may follow at once
   task automatic apb(input logic wr, input logic [23:0] a, input logic [31:0] d,
                      input logic [31:0] e, input logic err);
      int n;
      note_q.push_back({~wr, err, e});
      psel_i <= 1'b1;
      pwrite_i <= wr;
      paddr_i <= a;
      pwdata_i <= d;
      @(posedge clk_i);
      penable_i <= 1'b1;
      n = 0;
      do begin
         @(posedge clk_i);
         n++;
      end while (pready_o !== 1'b1 && n < 20);
      penable_i <= 1'b0;
      if (pready_o !== 1'b1) begin
         fail_count++;
         results();
      end
   endtask : apb

   task wr(input logic [23:0] a, input logic [31:0] d);
      apb(1'b1, a, d, 32'h0000_0000, 1'b0);
   endtask : wr

   task rd(input logic [23:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0000_0000, e, 1'b0);
   endtask : rd

   // Bus idle after a run of transfers
   task idle;
      psel_i <= 1'b0;
      @(posedge clk_i);
   endtask : idle

   // Core event, then entry pulse and mode level
   task automatic enter(input int kind, input logic [23:0] a, input int gap,
                        input logic ent, input logic md);
      core_u.pulse(kind, a, gap);
      @(negedge clk_i);
      chk_pin({7'h00, debug_entry_o}, {7'h00, ent});
      chk_pin({7'h00, debug_mode_o}, {7'h00, md});
      @(negedge clk_i);
      chk_pin({7'h00, debug_entry_o}, 8'h00);
      @(posedge clk_i);
   endtask : enter

   // Takes the oldest note at every completed transfer
   always @(posedge clk_i) begin
      if (psel_i && penable_i && pready_o === 1'b1 && note_q.size() > 0) begin
         chk_pin({7'h00, pslverr_o}, {7'h00, note_q[0].err});
         if (note_q[0].rd) chk_data(prdata_o, note_q[0].d);
         void'(note_q.pop_front());
      end
   end

   // Hang guard
   initial begin
      repeat (20000) @(posedge clk_i);
      fail_count++;
      results();
   end

   // Main sequence
   initial begin
      rst_i = 1'b1;
      psel_i = 1'b0;
      penable_i = 1'b0;
      pwrite_i = 1'b0;
      paddr_i = 24'h00_0000;
      pwdata_i = 32'h0000_0000;
      break_zero_addr_i = 24'h00_0000;
      void'($urandom(32'h472b4a0a));
      repeat (16) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      chk_pin({debug_mode_o, single_step_enable_o, irq_o, break_enable_o}, 8'h00);
      // Reset values, read-only places and an unmapped word
      rd(`CDB_OFF_PROC_ID, {24'h00_0000, ID});
      rd(`CDB_OFF_RAM_BASE, 32'h0000_07c0);
      rd(`CDB_OFF_CTL, 32'h0000_0000);
      for (int i = 0; i < 4; i++) rd(bar_a[i], 32'h0000_0000);
      rd(`CDB_OFF_STATUS, 32'h0000_0000);
      rd(`CDB_OFF_MASK, 32'h0000_0000);
      wr(`CDB_OFF_PROC_ID, 32'hffff_ffff);
      wr(`CDB_OFF_RAM_BASE, 32'hffff_ffff);
      rd(`CDB_OFF_PROC_ID, {24'h00_0000, ID});
      rd(`CDB_OFF_RAM_BASE, 32'h0000_07c0);
      apb(1'b0, 24'hff_ff88, 32'h0000_0000, 32'h0000_0000, 1'b1);
      apb(1'b1, 24'hff_ff88, 32'hffff_ffff, 32'h0000_0000, 1'b1);
      // Break addresses keep 24 bits each, top byte reads zero
      for (int i = 0; i < 4; i++) begin
         v[i] = (i == 3) ? 32'hffff_ffff : $urandom;
         wr(bar_a[i], v[i]);
      end
      for (int i = 0; i < 4; i++) rd(bar_a[i], v[i] & 32'h00ff_ffff);
      // All control bits written to one
      wr(`CDB_OFF_CTL, 32'hffff_ffff);
      rd(`CDB_OFF_CTL, 32'h0000_00ee);
      idle;
      chk_pin({1'b0, single_step_enable_o, 1'b0, break_enable_o}, 8'h5f);
      wr(`CDB_OFF_CTL, 32'h0000_0000);
      idle;
      // Request enters debug mode; flag sticks until a one is written
      enter(2, 24'h00_0000, 0, 1'b1, 1'b1);
      rd(`CDB_OFF_CTL, 32'h0000_0011);
      wr(`CDB_OFF_CTL, 32'h0000_0010);
      rd(`CDB_OFF_CTL, 32'h0000_0001);
      wr(`CDB_OFF_MASK, 32'h0000_0004);
      idle;
      chk_pin({7'h00, irq_o}, 8'h01);
      wr(`CDB_OFF_STATUS, 32'h0000_0004);
      idle;
      chk_pin({7'h00, irq_o}, 8'h00);
      enter(3, 24'h00_0000, 0, 1'b0, 1'b0);
      // Each break: ignored while disabled, taken once enabled
      for (int k = 0; k < 5; k++) begin
         v[0] = $urandom & 32'h00ff_ffff;
         if (k == 0) break_zero_addr_i <= v[0][23:0];
         else wr(bar_a[k-1], v[0]);
         idle;
         enter(0, v[0][23:0], 0, 1'b0, 1'b0);
         wr(`CDB_OFF_CTL, 32'h0000_0001 << bp[k]);
         idle;
         enter(0, v[0][23:0], k, 1'b1, 1'b1);
         rd(`CDB_OFF_STATUS, 32'h0000_0001);
         wr(`CDB_OFF_STATUS, 32'h0000_0007);
         idle;
         enter(3, 24'h00_0000, 0, 1'b0, 1'b0);
      end
      // Single step enters; a second step in debug mode is ignored
      wr(`CDB_OFF_CTL, 32'h0000_0002);
      idle;
      enter(1, 24'h00_0000, 3, 1'b1, 1'b1);
      enter(1, 24'h00_0000, 0, 1'b0, 1'b1);
      rd(`CDB_OFF_STATUS, 32'h0000_0002);
      idle;
      // Second reset in mid-run clears control and addresses
      rst_i <= 1'b1;
      @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      rd(`CDB_OFF_CTL, 32'h0000_0000);
      rd(`CDB_OFF_BAR4, 32'h0000_0000);
      idle;
      results();
   end
endmodule : tb_core_debug_break_registers
`default_nettype wire
